// ===== rtl/mhp_host.sv
// host end: apb slave registers that drive 8080 or 6800 cycles on the port
// assumes the port pins are synchronous to pclk; style strap is static
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - chip select low frames each cycle
// - select and direction choose cycle type
// - select comes from address bit zero; here it is the CTRL_CMD bit of the ctrl register
// - 8080 read strobe pulses low
// - 6800 read pin is active-high enable
// - 8080 write strobe pulses low
// - 6800 write pin gives direction
// - reset pin low resets the controller
// - interrupt pin reported to software
// - wait low means controller busy
// - never start or finish while busy
// - one shared bus, direction per cycle
// - data bus eight bits wide
// - strap selects 8080 or 6800
// - release all pins during auto-init
module mhp_host #(
  parameter int INIT_CYC = mhp_pkg::INIT_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        style_6800,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_out,
  mhp_if.host              port
);
  typedef enum {MHP_H_INIT, MHP_H_IDLE, MHP_H_SETUP, MHP_H_STROBE, MHP_H_HOLD} mhp_hstate_e;
  localparam logic [2:0] STB_LAST = 3'(mhp_pkg::STROBE_CYC - 1);
  mhp_hstate_e state, next_state;
  logic [31:0] init_cnt, next_init_cnt;
  logic [2:0]  cnt, next_cnt;
  logic        is_cmd, next_is_cmd, is_rd, next_is_rd, rst_req, next_rst_req;
  logic [7:0]  wdata, next_wdata, rdata, next_rdata;
  logic [mhp_pkg::ST_W-1:0] status, next_status, mask, next_mask;
  logic [31:0] next_prdata;
  logic        acc, wr_acc, rd_acc, done_ev;
  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // level interrupt from unmasked sticky bits
  assign irq_out = |(status & mask);
  // ------------------------------------------------------------
  // pin sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    next_cnt = cnt;
    next_is_cmd = is_cmd;
    next_is_rd = is_rd;
    next_rst_req = rst_req;
    next_wdata = wdata;
    next_rdata = rdata;
    next_mask = mask;
    next_prdata = prdata;
    done_ev = 1'b0;
    case (state)
      // wait init: pins released until cs rises or time runs out
      MHP_H_INIT: begin
        next_init_cnt = init_cnt + 32'd1;
        if (init_cnt >= INIT_CYC - 1 ||
            (init_cnt >= 32'(mhp_pkg::INIT_MIN_CYC) && port.cs_n)) begin
          next_state = MHP_H_IDLE;
        end
      end
      MHP_H_IDLE: begin
        // start only when wait is high
        if (wr_acc && paddr == mhp_pkg::REG_CTRL && pwdata[mhp_pkg::CTRL_GO] && port.wait_n) begin
          next_is_cmd = pwdata[mhp_pkg::CTRL_CMD];
          next_is_rd = pwdata[mhp_pkg::CTRL_READ];
          next_cnt = '0;
          next_state = MHP_H_SETUP;
        end
      end
      MHP_H_SETUP: begin
        next_state = MHP_H_STROBE;
      end
      MHP_H_STROBE: begin
        if (cnt != STB_LAST) begin
          next_cnt = cnt + 3'd1;
        end else if (port.wait_n) begin
          // strobe ends only when not busy; read data latched here
          if (is_rd) begin
            next_rdata = port.host_data_bus;
          end
          next_cnt = '0;
          next_state = MHP_H_HOLD;
        end
      end
      MHP_H_HOLD: begin
        if (cnt != STB_LAST) begin
          next_cnt = cnt + 3'd1;
        end else begin
          done_ev = 1'b1;
          next_state = MHP_H_IDLE;
        end
      end
      default: next_state = MHP_H_IDLE;
    endcase
    if (wr_acc && paddr == mhp_pkg::REG_CTRL) begin
      next_rst_req = pwdata[mhp_pkg::CTRL_RST];
    end
    if (wr_acc && paddr == mhp_pkg::REG_WDATA) begin
      next_wdata = pwdata[7:0];
    end
    if (wr_acc && paddr == mhp_pkg::REG_IMASK) begin
      next_mask = pwdata[mhp_pkg::ST_W-1:0];
    end
    // read mux; unmapped reads return zero
    if (psel && !penable && !pwrite) begin
      case (paddr)
        mhp_pkg::REG_CTRL:  next_prdata = {28'h0000000, rst_req, is_rd, is_cmd,
                                           state != MHP_H_IDLE};
        mhp_pkg::REG_WDATA: next_prdata = {24'h000000, wdata};
        mhp_pkg::REG_RDATA: next_prdata = {24'h000000, rdata};
        mhp_pkg::REG_STAT:  next_prdata = {28'h0000000, status};
        mhp_pkg::REG_IMASK: next_prdata = {28'h0000000, mask};
        default:            next_prdata = 32'h00000000;
      endcase
    end
  end
  // ------------------------------------------------------------
  // status: events set, read of status clears, set wins
  // ------------------------------------------------------------
  always_comb begin
    next_status = status;
    if (rd_acc && paddr == mhp_pkg::REG_STAT) begin
      // clear only what the setup-phase snapshot reported, so an event that
      // lands on the setup edge survives for the next read
      next_status = status & ~prdata[mhp_pkg::ST_W-1:0];
    end
    if (port.irq) next_status[mhp_pkg::ST_INT] = 1'b1;
    if (!port.wait_n) next_status[mhp_pkg::ST_BUSY] = 1'b1;
    if (done_ev) next_status[mhp_pkg::ST_DONE] = 1'b1;
    if (state == MHP_H_INIT && next_state == MHP_H_IDLE) begin
      next_status[mhp_pkg::ST_READY] = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MHP_H_INIT;
      init_cnt <= '0;
      cnt <= '0;
      is_cmd <= 1'b0;
      is_rd <= 1'b0;
      rst_req <= 1'b0;
      wdata <= '0;
      rdata <= '0;
      status <= '0;
      mask <= '0;
      prdata <= '0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      cnt <= next_cnt;
      is_cmd <= next_is_cmd;
      is_rd <= next_is_rd;
      rst_req <= next_rst_req;
      wdata <= next_wdata;
      rdata <= next_rdata;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
    end
  end
  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  logic active, strobe;
  assign active = state == MHP_H_SETUP || state == MHP_H_STROBE || state == MHP_H_HOLD;
  assign strobe = state == MHP_H_STROBE;
  assign port.host_drives = state != MHP_H_INIT;
  // chip select low across the whole cycle
  assign port.cs_n = ~active;
  // select acts as address bit zero
  assign port.cmd_data_select = is_cmd;
  assign port.rst_n = ~rst_req;
  assign port.rd_pin = style_6800 ? strobe : ~(strobe & is_rd);
  // write pin: strobe, or steady direction
  assign port.wr_pin = style_6800 ? (active ? is_rd : 1'b1) : ~(strobe & ~is_rd);
  assign port.host_data_bus_h = wdata;
  assign port.host_data_oe_h = active & ~is_rd;
endmodule
`default_nettype wire

// ===== common/mhp_pkg.sv
// package for the parallel host port: bus styles, cycle codes, timing counts
// assumes a single 50 MHz clock shared by both ends
`default_nettype none
package mhp_pkg;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 20;
  // strobe low/high times of the host side
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // device busy time after each accepted write
  localparam int BUSY_NS = 100;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  // auto-initialisation hold-off seen by the host (1 s)
  localparam longint INIT_NS = 64'd1000000000;
  localparam int INIT_CYC_DEF = int'(INIT_NS / CLK_NS);
  // cycles after reset before a high chip select is taken as init complete
  localparam int INIT_MIN_CYC = 3;
  // device's own busy period after reset before answering
  localparam int BOOT_CYC = 16;
  // apb register offsets of the host controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_IMASK = 8'h10;
  // ctrl fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_CMD = 1;
  localparam int CTRL_READ = 2;
  localparam int CTRL_RST = 3;
  // status / mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_INT = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_READY = 3;
  localparam int ST_W = 4;
  // bus styles (strap)
  typedef enum logic {MHP_BUS_8080, MHP_BUS_6800} mhp_style_e;
  // cycle type from cmd_data_select and direction
  typedef enum logic [1:0] {
    MHP_DATA_WR = 2'b00,
    MHP_DATA_RD = 2'b01,
    MHP_CMD_WR  = 2'b10,
    MHP_STAT_RD = 2'b11
  } mhp_cycle_e;
endpackage
`default_nettype wire

// ===== common/mhp_if.sv
// pin bundle between host controller and display port
// this bundle resolves the shared data wire from the two enables
`timescale 1ns/1ps
`default_nettype none
interface mhp_if;
  logic                     cs_n;
  logic                     cmd_data_select;
  logic                     rd_pin;
  logic                     wr_pin;
  logic                     rst_n;
  logic [mhp_pkg::DATA_W-1:0] host_data_bus_h;
  logic                     host_data_oe_h;
  logic [mhp_pkg::DATA_W-1:0] host_data_bus_d;
  logic                     host_data_oe_d;
  logic [mhp_pkg::DATA_W-1:0] host_data_bus;
  logic                     irq;
  logic                     wait_n;
  logic                     host_drives;
  // resolved wire level
  assign host_data_bus = host_data_oe_h ? host_data_bus_h :
                         host_data_oe_d ? host_data_bus_d : '1;
  modport dev (input cs_n, cmd_data_select, rd_pin, wr_pin, rst_n, host_data_bus,
               output host_data_bus_d, host_data_oe_d, irq, wait_n);
  modport host (output cs_n, cmd_data_select, rd_pin, wr_pin, rst_n, host_data_bus_h,
                host_data_oe_h, host_drives, input host_data_bus, irq, wait_n);
endinterface
`default_nettype wire

// ===== rtl/mhp_dev.sv
// device end: decodes host cycles, keeps command/data/status, drives wait and irq
// assumes pins synchronous to pclk; strap static after reset
`timescale 1ns/1ps
`default_nettype none
module mhp_dev (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       style_6800,
  input  wire logic       irq_event,
  input  wire logic [7:0] status_in,
  input  wire logic [7:0] rd_data_in,
  output logic            cmd_valid,
  output logic            data_valid,
  output logic [7:0]      wr_byte,
  output logic            data_rd_pulse,
  mhp_if.dev              port
);
  logic       strobe, strobe_q, is_read, rst_seen;
  logic       is_read_q, cmd_q;
  logic [4:0] busy_cnt, next_busy_cnt;
  logic       next_cmd_valid, next_data_valid, next_rd_pulse, irq_q, next_irq_q;
  logic [7:0] next_wr_byte, out_q, next_out_q;
  assign is_read = style_6800 ? port.wr_pin : 1'b1 & ~port.rd_pin;
  assign strobe = ~port.cs_n & (style_6800 ? port.rd_pin : (~port.rd_pin | ~port.wr_pin));
  // pin reset reloads the boot busy count and clears the pending interrupt
  assign rst_seen = ~port.rst_n;
  // ------------------------------------------------------------
  // cycle decode
  // ------------------------------------------------------------
  always_comb begin
    next_busy_cnt = busy_cnt != '0 ? busy_cnt - 5'd1 : '0;
    next_cmd_valid = 1'b0;
    next_data_valid = 1'b0;
    next_rd_pulse = 1'b0;
    next_wr_byte = wr_byte;
    next_out_q = out_q;
    next_irq_q = irq_q | irq_event;
    // cycle type latched at strobe end (writes) or start (reads)
    if (strobe && !strobe_q && is_read) begin
      next_out_q = port.cmd_data_select ? status_in : rd_data_in;
      next_rd_pulse = ~port.cmd_data_select;
      // status read clears pending interrupt
      if (port.cmd_data_select) next_irq_q = irq_event;
    end
    if (!strobe && strobe_q && !is_read_q) begin
      next_wr_byte = port.host_data_bus;
      next_cmd_valid = cmd_q;
      next_data_valid = ~cmd_q;
      next_busy_cnt = 5'(mhp_pkg::BUSY_CYC);
    end
    if (rst_seen) begin
      next_busy_cnt = 5'(mhp_pkg::BOOT_CYC);
      next_irq_q = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
      is_read_q <= 1'b0;
      cmd_q <= 1'b0;
      busy_cnt <= 5'(mhp_pkg::BOOT_CYC);
      cmd_valid <= 1'b0;
      data_valid <= 1'b0;
      data_rd_pulse <= 1'b0;
      wr_byte <= '0;
      out_q <= '0;
      irq_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
      is_read_q <= strobe ? is_read : is_read_q;
      cmd_q <= strobe ? port.cmd_data_select : cmd_q;
      busy_cnt <= next_busy_cnt;
      cmd_valid <= next_cmd_valid;
      data_valid <= next_data_valid;
      data_rd_pulse <= next_rd_pulse;
      wr_byte <= next_wr_byte;
      out_q <= next_out_q;
      irq_q <= next_irq_q;
    end
  end
  assign port.irq = irq_q;
  assign port.wait_n = busy_cnt == '0;
  assign port.host_data_bus_d = out_q;
  assign port.host_data_oe_d = strobe & is_read & strobe_q;
endmodule
`default_nettype wire

// ===== test/mhp_port_sva.sv
// checker for the pin bundle between host and device ends
// assumes all pins move on pclk and the strap is static out of reset
`timescale 1ns/1ps
`default_nettype none
module mhp_port_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic style_6800,
  input wire logic cs_n,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic host_data_oe_h,
  input wire logic host_data_oe_d,
  input wire logic wait_n,
  input wire logic irq,
  input wire logic host_drives
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // strobes, enables and bus ownership
  // ----------------------------------------
  property p_sel_8080;
    !style_6800 && host_drives && !(rd_pin && wr_pin) |-> !cs_n;
  endproperty
  a_sel_8080: assert property (p_sel_8080) else $error("8080 strobe outside select");
  property p_sel_6800;
    style_6800 && host_drives && rd_pin |-> !cs_n;
  endproperty
  a_sel_6800: assert property (p_sel_6800) else $error("6800 enable outside select");
  property p_one_strobe;
    !style_6800 && host_drives |-> rd_pin || wr_pin;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both 8080 strobes low");
  property p_wr_len;
    !style_6800 && host_drives && $fell(wr_pin) |-> !wr_pin [*3];
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe too short");
  property p_dir_stable;
    style_6800 && rd_pin && $past(rd_pin) |-> $stable(wr_pin);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved in enable");
  property p_no_fight;
    !(host_data_oe_h && host_data_oe_d);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
  property p_dev_read_only;
    host_data_oe_d |-> wr_pin && !cs_n;
  endproperty
  a_dev_read_only: assert property (p_dev_read_only) else $error("device drives off a read");
  property p_released;
    !host_drives |-> !host_data_oe_h;
  endproperty
  a_released: assert property (p_released) else $error("host drives during init");
  property p_start_idle;
    host_drives && $fell(cs_n) |-> $past(wait_n);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("cycle started while busy");
  c_write: cover property (!cs_n && !wr_pin);
  c_read: cover property (host_data_oe_d);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench: host end and device end joined by the pin bundle
// assumes apb answers by pready; small init hold-off of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        style_6800 = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        irq_out;
  logic        irq_event = 1'b0;
  logic [7:0]  status_in = 8'h5A;
  logic [7:0]  rd_data_in = 8'hC3;
  logic        cmd_valid;
  logic        data_valid;
  logic        data_rd_pulse;
  logic [7:0]  wr_byte;
  logic [7:0]  last_byte;
  logic [31:0] rv;
  int          n_data = 0;
  int          n_cmd = 0;
  int          n_rdp = 0;
  int          err_count = 0;
  int          checks_done = 0;
  always #10 pclk = ~pclk;
  mhp_if port_if ();
  mhp_host #(.INIT_CYC(20)) u_mhp_host (.pclk(pclk), .presetn(presetn),
    .style_6800(style_6800), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .irq_out(irq_out), .port(port_if));
  mhp_dev u_mhp_dev (.pclk(pclk), .presetn(presetn), .style_6800(style_6800),
    .irq_event(irq_event), .status_in(status_in), .rd_data_in(rd_data_in),
    .cmd_valid(cmd_valid), .data_valid(data_valid), .wr_byte(wr_byte),
    .data_rd_pulse(data_rd_pulse), .port(port_if));
  mhp_port_sva u_sva (.pclk(pclk), .presetn(presetn), .style_6800(style_6800),
    .cs_n(port_if.cs_n), .rd_pin(port_if.rd_pin), .wr_pin(port_if.wr_pin),
    .host_data_oe_h(port_if.host_data_oe_h), .host_data_oe_d(port_if.host_data_oe_d),
    .wait_n(port_if.wait_n), .irq(port_if.irq), .host_drives(port_if.host_drives));
  // ----------------------------------------
  // device-side monitor and shared tasks
  // ----------------------------------------
  // counts pulses seen before the edge updates them, so each is seen once
  always @(posedge pclk) begin
    if (data_valid === 1'b1) begin
      n_data++;
      last_byte = wr_byte;
    end
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_byte = wr_byte;
    end
    if (data_rd_pulse === 1'b1) n_rdp++;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; the trailing idle edge keeps strobes from doubling up
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; there is no timeout of its own
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_for(input logic v);
    int n;
    n = 0;
    while (port_if.wait_n !== v && n < 60) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic poll(input int bit_no);
    int n;
    n = 0;
    do begin
      apb(1'b0, mhp_pkg::REG_STAT, 32'h00000000);
      n++;
    end while (rv[bit_no] !== 1'b1 && n < 40);
  endtask
  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pins released", 32'h0, {31'h0, port_if.host_drives});
    poll(mhp_pkg::ST_READY);
    chk("init ready", 32'h1, {31'h0, rv[mhp_pkg::ST_READY]});
    wait_for(1'b1);
    chk("device idle", 32'h1, {31'h0, port_if.wait_n});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int n0;
    int c0;
    int r0;
    int n;
    logic [7:0] b;
    // every cycle type in both bus styles; strap only changes under reset
    for (int s = 0; s < 2; s++) begin
      style_6800 <= s[0];
      reset_dut();
      for (int k = 0; k < 4; k++) begin
        n0 = n_data;
        c0 = n_cmd;
        r0 = n_rdp;
        b = 8'h96 ^ k[7:0];
        apb(1'b1, mhp_pkg::REG_WDATA, {24'h0, b});
        apb(1'b1, mhp_pkg::REG_CTRL, {29'h0, k[0], k[1], 1'b1});
        poll(mhp_pkg::ST_DONE);
        chk("cycle done", 32'h1, {31'h0, rv[mhp_pkg::ST_DONE]});
        chk("busy seen", {31'h0, ~k[0]}, {31'h0, rv[mhp_pkg::ST_BUSY]});
        chk("data writes", n0 + (k == 0), n_data);
        chk("cmd writes", c0 + (k == 2), n_cmd);
        chk("data reads", r0 + (k == 1), n_rdp);
        if (k[0]) begin
          apb(1'b0, mhp_pkg::REG_RDATA, 32'h00000000);
          chk("read byte", {24'h0, (k == 1) ? rd_data_in : status_in}, rv);
        end else begin
          chk("written byte", {24'h0, b}, {24'h0, last_byte});
        end
      end
    end
    // interrupt raised, seen in status, then masked off
    apb(1'b1, mhp_pkg::REG_IMASK, 32'h00000002);
    irq_event <= 1'b1;
    @(posedge pclk);
    irq_event <= 1'b0;
    n = 0;
    while (irq_out !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("irq out", 32'h1, {31'h0, irq_out});
    apb(1'b0, mhp_pkg::REG_STAT, 32'h00000000);
    chk("irq status", 32'h1, {31'h0, rv[mhp_pkg::ST_INT]});
    apb(1'b1, mhp_pkg::REG_IMASK, 32'h00000000);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    apb(1'b0, 8'h20, 32'h00000000);
    chk("unmapped", 32'h0, rv);
    // reset pin holds the device busy, released afterwards
    apb(1'b1, mhp_pkg::REG_CTRL, 32'h00000008);
    wait_for(1'b0);
    chk("reset busy", 32'h0, {31'h0, port_if.wait_n});
    apb(1'b1, mhp_pkg::REG_CTRL, 32'h00000000);
    wait_for(1'b1);
    chk("reset over", 32'h1, {31'h0, port_if.wait_n});
    close_out();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
